// *** bmcd_defs.svh ***
// Constants for the battery monitor command decoder
// Overview of operation
// - Codes 0x010 and 0x012 read housekeeping groups A and B.
// - Cell conversion pattern 01xx11d0ccc starts a cell conversion.
// - Open-wire pattern 01xxb1d1ccc; bias 0 pull-down, 1 pull-up.
// - Pattern 01xxpp00111 starts a cell self check.
// - Pattern 10xx1100ggg starts an aux conversion.
// - Pattern 10xxpp00111 starts an aux self check.
// - Pattern 10xx1101sss converts housekeeping channels; 000 all four.
// - Pattern 10xxpp01111 starts a housekeeping self check.
// - Pattern 10xx11d1111 converts all cells plus first two GPIOs.
// - Codes 0x711, 0x712, 0x713 wipe cell, aux, housekeeping results.
// - Code 0x714 polls whether a conversion is still running.
// - Code 0x715 starts mux check, progress reportable by polling.
// - Code 0x721 writes the link buffer group.
// - Code 0x722 reads the link buffer group.
// - Cell pick 000 all cells, 001-110 one pair n and n+6.
// - Aux pick 000 all GPIO plus reference, 001-101 one, 110 ref.
// - First byte: five zeros broadcast, or 1 plus four-bit address.
// - Packet error code covers the whole 16-bit command.
// - Housekeeping picks 5 and 6 act as aux conversion, same pick.
`ifndef BMCD_DEFS_SVH
`define BMCD_DEFS_SVH
`define BMCD_OP_WR_SETUP 11'h001
`define BMCD_OP_RD_SETUP 11'h002
`define BMCD_OP_RD_CELLS_A 11'h004
`define BMCD_OP_RD_CELLS_B 11'h006
`define BMCD_OP_RD_CELLS_C 11'h008
`define BMCD_OP_RD_CELLS_D 11'h00a
`define BMCD_OP_RD_AUX_A 11'h00c
`define BMCD_OP_RD_AUX_B 11'h00e
`define BMCD_OP_RD_HK_A 11'h010
`define BMCD_OP_RD_HK_B 11'h012
`define BMCD_OP_WIPE_CELL 11'h711
`define BMCD_OP_WIPE_AUX 11'h712
`define BMCD_OP_WIPE_HK 11'h713
`define BMCD_OP_POLL 11'h714
`define BMCD_OP_MUX_CHECK 11'h715
`define BMCD_OP_WR_LINK 11'h721
`define BMCD_OP_RD_LINK 11'h722
`define BMCD_ST1_FAST 16'h9565
`define BMCD_ST1_MID 16'h9553
`define BMCD_ST1_SLOW 16'h9555
`define BMCD_ST2_FAST 16'h6a9a
`define BMCD_ST2_MID 16'h6aac
`define BMCD_ST2_SLOW 16'h6aaa
`define BMCD_CLK_HZ 50000000
// Conversion times in microseconds, tenths where printed so
`define BMCD_T_FULL_27K_US 1100
`define BMCD_T_FULL_14K_US 1300
`define BMCD_T_FULL_7K_US 2300
`define BMCD_T_FULL_3K_US 3000
`define BMCD_T_FULL_2K_US 4400
`define BMCD_T_FULL_26H_US 201000
`define BMCD_T_ONE_27K_US 201
`define BMCD_T_ONE_14K_US 230
`define BMCD_T_ONE_7K_US 405
`define BMCD_T_ONE_3K_US 501
`define BMCD_T_ONE_2K_US 754
`define BMCD_T_ONE_26H_US 34000
`define BMCD_T_HK_27K_US 748
`define BMCD_T_HK_14K_US 865
`define BMCD_T_HK_7K_US 1600
`define BMCD_T_HK_3K_US 2000
`define BMCD_T_HK_2K_US 3000
`define BMCD_T_HK_26H_US 134000
`define BMCD_US_CYC(us) ((us) * (`BMCD_CLK_HZ / 1000000))
`endif

// *** bmcd_field_decode.sv ***
// Combinational code-to-command field decoder
`timescale 1ns/10ps
`default_nettype none
`include "bmcd_defs.svh"
module bmcd_field_decode (
	input wire logic [10:0] code_i,
	input wire logic rate_table_alt_i,
	output bmcd_pkg::bmcd_cmd_t cmd_o
);
	import bmcd_pkg::*;
	always_comb begin
		cmd_o = '0;
		cmd_o.op = BMCD_OP_NONE;
		cmd_o.adc_rate_pick = code_i[8:7];
		cmd_o.balance_allow = code_i[4];
		cmd_o.open_wire_bias_dir = code_i[6];
		cmd_o.diag_pattern_pick = code_i[6:5];
		cmd_o.cell_pair_pick = code_i[2:0];
		cmd_o.aux_input_pick = code_i[2:0];
		cmd_o.housekeeping_pick = code_i[2:0];
		// Rate table selection
		case (code_i[8:7])
			2'b01: cmd_o.rate = rate_table_alt_i ? 3'h1 : 3'h0;
			2'b10: cmd_o.rate = rate_table_alt_i ? 3'h3 : 3'h2;
			2'b11: cmd_o.rate = rate_table_alt_i ? 3'h4 : 3'h5;
			default: cmd_o.rate = rate_table_alt_i ? 3'h1 : 3'h0;
		endcase
		case (code_i)
			`BMCD_OP_WR_SETUP: cmd_o.op = BMCD_OP_WR_SETUP;
			`BMCD_OP_RD_SETUP: cmd_o.op = BMCD_OP_RD_SETUP;
			`BMCD_OP_RD_CELLS_A, `BMCD_OP_RD_CELLS_B,
			`BMCD_OP_RD_CELLS_C, `BMCD_OP_RD_CELLS_D: begin
				cmd_o.op = BMCD_OP_RD_CELLS;
				cmd_o.group = code_i[2:1] - 2'h2;
			end
			`BMCD_OP_RD_AUX_A, `BMCD_OP_RD_AUX_B: begin
				cmd_o.op = BMCD_OP_RD_AUX;
				cmd_o.group = {1'b0, code_i[1]};
			end
			`BMCD_OP_RD_HK_A, `BMCD_OP_RD_HK_B: begin
				cmd_o.op = BMCD_OP_RD_HK;
				cmd_o.group = {1'b0, code_i[1]};
			end
			`BMCD_OP_WIPE_CELL: cmd_o.op = BMCD_OP_WIPE_CELL;
			`BMCD_OP_WIPE_AUX: cmd_o.op = BMCD_OP_WIPE_AUX;
			`BMCD_OP_WIPE_HK: cmd_o.op = BMCD_OP_WIPE_HK;
			`BMCD_OP_POLL: cmd_o.op = BMCD_OP_POLL;
			`BMCD_OP_MUX_CHECK: cmd_o.op = BMCD_OP_MUX_CHECK;
			`BMCD_OP_WR_LINK: cmd_o.op = BMCD_OP_WR_LINK;
			`BMCD_OP_RD_LINK: cmd_o.op = BMCD_OP_RD_LINK;
			default: begin
				if (code_i[10:9] == 2'b01 && code_i[8:7] != 2'b00) begin
					if (code_i[6:5] == 2'b11 && code_i[3] == 1'b0)
						cmd_o.op = BMCD_OP_CONV_CELLS;
					else if (code_i[5] && code_i[3])
						cmd_o.op = BMCD_OP_CONV_OW;
					else if (code_i[4:0] == 5'h07 &&
							^code_i[6:5])
						cmd_o.op = BMCD_OP_CELL_ST;
				end else if (code_i[10:9] == 2'b10 &&
						code_i[8:7] != 2'b00) begin
					// Combined code with permission 0 overlaps 1101 prefix
					if (code_i[6:5] == 2'b11 && code_i[3:0] == 4'hf)
						cmd_o.op = BMCD_OP_CONV_CAX;
					else if (code_i[6:3] == 4'hc)
						cmd_o.op = BMCD_OP_CONV_AUX;
					else if (code_i[6:3] == 4'hd) begin
						if (code_i[2:0] == 3'h5 || code_i[2:0] == 3'h6)
							cmd_o.op = BMCD_OP_CONV_AUX;
						else if (code_i[2:0] <= 3'h4)
							cmd_o.op = BMCD_OP_CONV_HK;
					end else if (code_i[4:0] == 5'h07 && ^code_i[6:5])
						cmd_o.op = BMCD_OP_AUX_ST;
					else if (code_i[4:0] == 5'h0f && ^code_i[6:5])
						cmd_o.op = BMCD_OP_HK_ST;
				end
			end
		endcase
		cmd_o.full_set = (code_i[2:0] == 3'h0);
	end
endmodule : bmcd_field_decode
`default_nettype wire

// *** bmcd_host_model.sv ***
// Host controller model issuing command words
`timescale 1ns/10ps
`default_nettype none
module bmcd_host_model (
	input wire logic clock_i,
	output logic cmd_valid_o,
	output logic [15:0] cmd_word_o,
	output logic pec_ok_o
);
	initial begin
		cmd_valid_o = 1'b0;
		cmd_word_o = 16'h0;
		pec_ok_o = 1'b0;
	end
	// One-cycle request, lines scrambled afterwards
	task automatic send(input logic [15:0] w, input logic packet_error_code);
		@(posedge clock_i);
		cmd_valid_o <= 1'b1;
		cmd_word_o <= w;
		pec_ok_o <= packet_error_code;
		@(posedge clock_i);
		cmd_valid_o <= 1'b0;
		cmd_word_o <= ~w;
		pec_ok_o <= ~packet_error_code;
	endtask : send
endmodule : bmcd_host_model
`default_nettype wire

// *** bmcd_monitor.sv ***
// Port-level assertion checker for the command decoder
`timescale 1ns/10ps
`default_nettype none
module bmcd_monitor (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic cmd_valid_i,
	input wire logic [15:0] cmd_word_i,
	input wire logic pec_ok_i,
	input wire logic [3:0] dev_addr_i,
	input wire logic cmd_accept_o,
	input wire bmcd_pkg::bmcd_cmd_t cmd_o,
	input wire logic read_group_o,
	input wire logic write_group_o,
	input wire logic conv_start_o,
	input wire logic wipe_cells_o,
	input wire logic busy_o,
	input wire logic discharge_hold_o,
	input wire logic bias_pull_up_o
);
	import bmcd_pkg::*;
	logic go;
	// Good broadcast request
	assign go = cmd_valid_i && pec_ok_i && !cmd_word_i[15];
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!arst_n_i);
	AST_ACC_CAUSE: assert property (
		cmd_accept_o |-> $past(cmd_valid_i) && $past(pec_ok_i))
		else $error("accept without good request");
	AST_PEC_BAD: assert property (
		cmd_valid_i && !pec_ok_i |=> !cmd_accept_o)
		else $error("bad error code accepted");
	AST_ADDR_MISS: assert property (
		cmd_valid_i && cmd_word_i[15] && cmd_word_i[14:11] != dev_addr_i
		|=> !cmd_accept_o)
		else $error("foreign address accepted");
	AST_BCAST_BITS: assert property (
		cmd_valid_i && !cmd_word_i[15] && cmd_word_i[14:11] != 4'h0
		|=> !cmd_accept_o)
		else $error("broadcast with address bits accepted");
	AST_HK_READ: assert property (
		go && cmd_word_i[14:0] == 15'h0010 |=> read_group_o && cmd_accept_o)
		else $error("housekeeping read not decoded");
	AST_WIPE_CELL: assert property (
		go && cmd_word_i[14:0] == 15'h0711 |=> wipe_cells_o)
		else $error("cell wipe missing");
	AST_LINK_WR: assert property (
		go && cmd_word_i[14:0] == 15'h0721 |=> write_group_o && !read_group_o)
		else $error("link buffer write not decoded");
	AST_MUX_START: assert property (
		go && cmd_word_i[14:0] == 15'h0715 && !busy_o
		|=> conv_start_o && busy_o)
		else $error("mux check did not start");
	AST_BUSY_CAUSE: assert property (
		$rose(busy_o) |-> conv_start_o)
		else $error("busy without start");
	AST_HOLD: assert property (
		discharge_hold_o |-> busy_o)
		else $error("discharge held while idle");
	AST_HOLD_RISE: assert property (
		$rose(discharge_hold_o) |-> conv_start_o && !cmd_o.balance_allow)
		else $error("discharge held wrongly");
	AST_HOLD_SET: assert property (
		conv_start_o && cmd_o.op == BMCD_OP_CONV_CELLS
		|-> discharge_hold_o == !cmd_o.balance_allow)
		else $error("discharge hold does not follow permission");
	AST_BIAS: assert property (
		bias_pull_up_o |-> busy_o)
		else $error("pull-up bias while idle");
	AST_BIAS_RISE: assert property (
		$rose(bias_pull_up_o) |-> conv_start_o && cmd_o.open_wire_bias_dir)
		else $error("pull-up bias wrongly");
	AST_BIAS_SET: assert property (
		conv_start_o && cmd_o.op == BMCD_OP_CONV_OW
		|-> bias_pull_up_o == cmd_o.open_wire_bias_dir)
		else $error("bias does not follow direction bit");
	AST_START_ONCE: assert property (
		conv_start_o |=> !conv_start_o)
		else $error("start pulse too long");
endmodule : bmcd_monitor
bind bmcd_top bmcd_monitor mon (.clock_i, .arst_n_i, .cmd_valid_i,
	.cmd_word_i, .pec_ok_i, .dev_addr_i, .cmd_accept_o, .cmd_o,
	.read_group_o, .write_group_o, .conv_start_o, .wipe_cells_o,
	.busy_o, .discharge_hold_o, .bias_pull_up_o);
`default_nettype wire

// *** bmcd_pkg.sv ***
// Types for the battery monitor command decoder
package bmcd_pkg;
	typedef enum logic [4:0] {
		BMCD_OP_NONE, BMCD_OP_WR_SETUP, BMCD_OP_RD_SETUP,
		BMCD_OP_RD_CELLS, BMCD_OP_RD_AUX, BMCD_OP_RD_HK,
		BMCD_OP_CONV_CELLS, BMCD_OP_CONV_OW, BMCD_OP_CELL_ST,
		BMCD_OP_CONV_AUX, BMCD_OP_AUX_ST, BMCD_OP_CONV_HK,
		BMCD_OP_HK_ST, BMCD_OP_CONV_CAX, BMCD_OP_WIPE_CELL,
		BMCD_OP_WIPE_AUX, BMCD_OP_WIPE_HK, BMCD_OP_POLL,
		BMCD_OP_MUX_CHECK, BMCD_OP_WR_LINK, BMCD_OP_RD_LINK
	} bmcd_op_t;
	// Rate index: 0 27k,1 14k,2 7k,3 3k,4 2k,5 26Hz
	typedef logic [2:0] bmcd_rate_t;
	typedef struct packed {
		bmcd_op_t op;
		logic [1:0] group;
		logic [1:0] adc_rate_pick;
		bmcd_rate_t rate;
		logic balance_allow;
		logic open_wire_bias_dir;
		logic [1:0] diag_pattern_pick;
		logic [2:0] cell_pair_pick;
		logic [2:0] aux_input_pick;
		logic [2:0] housekeeping_pick;
		logic full_set;
	} bmcd_cmd_t;
	typedef struct packed {
		logic addressed;
		logic [3:0] addr;
		logic [10:0] code;
	} bmcd_frame_t;
endpackage : bmcd_pkg

// *** bmcd_top.sv ***
// Battery monitor command decoder top: framing check, dispatch, timing
`timescale 1ns/10ps
`default_nettype none
`include "bmcd_defs.svh"
module bmcd_top (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic cmd_valid_i,
	input wire logic [15:0] cmd_word_i,
	input wire logic pec_ok_i,
	input wire logic [3:0] dev_addr_i,
	input wire logic rate_table_alt_i,
	output logic cmd_accept_o,
	output bmcd_pkg::bmcd_cmd_t cmd_o,
	output logic read_group_o,
	output logic write_group_o,
	output logic conv_start_o,
	output logic wipe_cells_o,
	output logic wipe_aux_o,
	output logic wipe_hk_o,
	output logic busy_o,
	output logic poll_busy_o,
	output logic discharge_hold_o,
	output logic bias_pull_up_o,
	output logic [11:0] cell_enable_o,
	output logic [5:0] aux_enable_o,
	output logic [3:0] hk_enable_o,
	output logic self_check_o,
	output logic [15:0] self_check_value_o
);
	import bmcd_pkg::*;
	typedef enum logic [1:0] {
		BMCD_IDLE = 2'b00,
		BMCD_RUN = 2'b01,
		BMCD_DONE = 2'b11
	} bmcd_state_t;
	logic rst_s1_q, rst_n_q;
	bmcd_frame_t frame;
	bmcd_cmd_t dec;
	logic frame_ok;
	logic start_conv;
	logic [23:0] cycles;
	logic [23:0] count_q;
	bmcd_state_t state_q;
	bmcd_cmd_t cmd_q;
	bmcd_cmd_t conv_q;
	logic conv_op;
	logic [15:0] st_val;
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end
	assign frame = cmd_word_i;
	// Broadcast needs five zeros; addressed needs matching address
	// Whole 16-bit word is covered by the error code
	assign frame_ok = cmd_valid_i && pec_ok_i &&
		(frame.addressed ? (frame.addr == dev_addr_i)
			: (frame.addr == 4'h0));
	bmcd_field_decode u_dec (
		.code_i(frame.code),
		.rate_table_alt_i(rate_table_alt_i),
		.cmd_o(dec)
	);
	assign conv_op = dec.op inside {BMCD_OP_CONV_CELLS, BMCD_OP_CONV_OW,
		BMCD_OP_CELL_ST, BMCD_OP_CONV_AUX, BMCD_OP_AUX_ST,
		BMCD_OP_CONV_HK, BMCD_OP_HK_ST, BMCD_OP_CONV_CAX,
		BMCD_OP_MUX_CHECK};
	// Start refused while a conversion runs
	assign start_conv = frame_ok && state_q != BMCD_RUN && conv_op;
	// Conversion length from rate and selection width
	function automatic logic [23:0] conv_cycles(input bmcd_cmd_t c);
		logic [23:0] r;
		logic hk, one;
		r = 24'h0;
		hk = (c.op == BMCD_OP_CONV_HK || c.op == BMCD_OP_HK_ST);
		one = !c.full_set && (c.op == BMCD_OP_CONV_CELLS ||
			c.op == BMCD_OP_CONV_OW || c.op == BMCD_OP_CONV_AUX ||
			c.op == BMCD_OP_CONV_HK);
		case (c.rate)
			3'h0: r = 24'(hk && !one ? `BMCD_US_CYC(`BMCD_T_HK_27K_US)
				: one ? `BMCD_US_CYC(`BMCD_T_ONE_27K_US)
				: `BMCD_US_CYC(`BMCD_T_FULL_27K_US));
			3'h1: r = 24'(hk && !one ? `BMCD_US_CYC(`BMCD_T_HK_14K_US)
				: one ? `BMCD_US_CYC(`BMCD_T_ONE_14K_US)
				: `BMCD_US_CYC(`BMCD_T_FULL_14K_US));
			3'h2: r = 24'(hk && !one ? `BMCD_US_CYC(`BMCD_T_HK_7K_US)
				: one ? `BMCD_US_CYC(`BMCD_T_ONE_7K_US)
				: `BMCD_US_CYC(`BMCD_T_FULL_7K_US));
			3'h3: r = 24'(hk && !one ? `BMCD_US_CYC(`BMCD_T_HK_3K_US)
				: one ? `BMCD_US_CYC(`BMCD_T_ONE_3K_US)
				: `BMCD_US_CYC(`BMCD_T_FULL_3K_US));
			3'h4: r = 24'(hk && !one ? `BMCD_US_CYC(`BMCD_T_HK_2K_US)
				: one ? `BMCD_US_CYC(`BMCD_T_ONE_2K_US)
				: `BMCD_US_CYC(`BMCD_T_FULL_2K_US));
			default: r = 24'(hk && !one
				? `BMCD_US_CYC(`BMCD_T_HK_26H_US)
				: one ? `BMCD_US_CYC(`BMCD_T_ONE_26H_US)
				: `BMCD_US_CYC(`BMCD_T_FULL_26H_US));
		endcase
		return r;
	endfunction : conv_cycles
	assign cycles = conv_cycles(dec);
	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= BMCD_IDLE;
			count_q <= 24'h0;
		end else begin
			case (state_q)
				BMCD_IDLE, BMCD_DONE: begin
					if (start_conv) begin
						state_q <= BMCD_RUN;
						count_q <= cycles;
					end
				end
				BMCD_RUN: begin
					if (count_q <= 24'h1)
						state_q <= BMCD_DONE;
					count_q <= count_q - 24'h1;
				end
				default: state_q <= BMCD_IDLE;
			endcase
		end
	end
	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cmd_q <= '0;
			cmd_accept_o <= 1'b0;
			read_group_o <= 1'b0;
			write_group_o <= 1'b0;
			conv_start_o <= 1'b0;
			wipe_cells_o <= 1'b0;
			wipe_aux_o <= 1'b0;
			wipe_hk_o <= 1'b0;
		end else begin
			cmd_accept_o <= frame_ok && dec.op != BMCD_OP_NONE;
			read_group_o <= frame_ok && (dec.op inside {BMCD_OP_RD_SETUP,
				BMCD_OP_RD_CELLS, BMCD_OP_RD_AUX, BMCD_OP_RD_HK,
				BMCD_OP_RD_LINK});
			write_group_o <= frame_ok && (dec.op == BMCD_OP_WR_SETUP ||
				dec.op == BMCD_OP_WR_LINK);
			conv_start_o <= start_conv;
			wipe_cells_o <= frame_ok && dec.op == BMCD_OP_WIPE_CELL;
			wipe_aux_o <= frame_ok && dec.op == BMCD_OP_WIPE_AUX;
			wipe_hk_o <= frame_ok && dec.op == BMCD_OP_WIPE_HK;
			if (frame_ok && dec.op != BMCD_OP_NONE &&
					(start_conv || !conv_op))
				cmd_q <= dec;
		end
	end
	assign cmd_o = cmd_q;
	// Running conversion kept apart from later reads and polls
	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q)
			conv_q <= '0;
		else if (start_conv)
			conv_q <= dec;
	end
	assign busy_o = (state_q == BMCD_RUN);
	// Poll answer: high while busy, mirrors running state
	assign poll_busy_o = busy_o && cmd_q.op == BMCD_OP_POLL;
	// Discharge held off while a cell, open-wire or combined conversion runs without permission
	assign discharge_hold_o = busy_o && !conv_q.balance_allow &&
		(conv_q.op inside {BMCD_OP_CONV_CELLS, BMCD_OP_CONV_OW,
		BMCD_OP_CONV_CAX});
	assign bias_pull_up_o = busy_o && conv_q.op == BMCD_OP_CONV_OW &&
		conv_q.open_wire_bias_dir;
	// Per-cell enable: all, or pair n and n+6
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_pair
			logic sel;
			assign sel = busy_o && (conv_q.op inside {BMCD_OP_CONV_CELLS,
				BMCD_OP_CONV_OW, BMCD_OP_CONV_CAX, BMCD_OP_CELL_ST}) &&
				(conv_q.cell_pair_pick == 3'h0 ||
				conv_q.op == BMCD_OP_CONV_CAX ||
				conv_q.op == BMCD_OP_CELL_ST ||
				conv_q.cell_pair_pick == 3'(gi + 1));
			assign cell_enable_o[gi] = sel;
			assign cell_enable_o[gi + 6] = sel;
		end
		for (gi = 0; gi < 6; gi++) begin : g_aux
			// Aux pick: 000 all five plus ref, 001-110 one input, 111 none
			assign aux_enable_o[gi] = busy_o &&
				((conv_q.op == BMCD_OP_CONV_AUX &&
				(conv_q.aux_input_pick == 3'h0 ||
				conv_q.aux_input_pick == 3'(gi + 1))) ||
				conv_q.op == BMCD_OP_AUX_ST ||
				(conv_q.op == BMCD_OP_CONV_CAX && gi < 2));
		end
		for (gi = 0; gi < 4; gi++) begin : g_hk
			assign hk_enable_o[gi] = busy_o &&
				((conv_q.op == BMCD_OP_CONV_HK &&
				(conv_q.housekeeping_pick == 3'h0 ||
				conv_q.housekeeping_pick == 3'(gi + 1))) ||
				conv_q.op == BMCD_OP_HK_ST);
		end
	endgenerate
	assign self_check_o = conv_q.op inside {BMCD_OP_CELL_ST,
		BMCD_OP_AUX_ST, BMCD_OP_HK_ST};
	// Fixed self-check result by pattern and rate
	always_comb begin
		st_val = 16'h0000;
		if (conv_q.diag_pattern_pick == 2'b01)
			st_val = (conv_q.rate == 3'h0) ? `BMCD_ST1_FAST
				: (conv_q.rate == 3'h1) ? `BMCD_ST1_MID : `BMCD_ST1_SLOW;
		else if (conv_q.diag_pattern_pick == 2'b10)
			st_val = (conv_q.rate == 3'h0) ? `BMCD_ST2_FAST
				: (conv_q.rate == 3'h1) ? `BMCD_ST2_MID : `BMCD_ST2_SLOW;
	end
	always_ff @(posedge clock_i or negedge rst_n_q) begin
		if (!rst_n_q)
			self_check_value_o <= 16'h0000;
		else if (self_check_o)
			self_check_value_o <= st_val;
		else
			self_check_value_o <= 16'h0000;
	end
endmodule : bmcd_top
`default_nettype wire

// *** tb_battery_monitor_cmd_decoder.sv ***
// Self-checking bench for the command decoder
`timescale 1ns/10ps
`default_nettype none
`include "bmcd_defs.svh"
module tb_battery_monitor_cmd_decoder;
	import bmcd_pkg::*;
	typedef struct {
		logic [15:0] w;
		logic packet_error_code;
		logic [5:0] pl;
		bmcd_op_t op;
	} bmcd_row_t;
	logic clock_i, arst_n_i, cmd_valid_i, pec_ok_i, rate_table_alt_i;
	logic [15:0] cmd_word_i, self_check_value_o;
	logic [3:0] dev_addr_i, hk_enable_o;
	logic cmd_accept_o, read_group_o, write_group_o, conv_start_o;
	logic wipe_cells_o, wipe_aux_o, wipe_hk_o, busy_o, poll_busy_o;
	logic discharge_hold_o, bias_pull_up_o, self_check_o;
	logic [11:0] cell_enable_o;
	logic [5:0] aux_enable_o, pl;
	bmcd_cmd_t cmd_o;
	bmcd_op_t last;
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int t0;
	// Pulses: accept, read, write, wipe cell, aux, hk
	bmcd_row_t rows [0:22] = '{
		'{16'h0001, 1, 6'h28, BMCD_OP_WR_SETUP},
		'{16'h0002, 1, 6'h30, BMCD_OP_RD_SETUP},
		'{16'h0004, 1, 6'h30, BMCD_OP_RD_CELLS},
		'{16'h0006, 1, 6'h30, BMCD_OP_RD_CELLS},
		'{16'h0008, 1, 6'h30, BMCD_OP_RD_CELLS},
		'{16'h000a, 1, 6'h30, BMCD_OP_RD_CELLS},
		'{16'h000c, 1, 6'h30, BMCD_OP_RD_AUX},
		'{16'h000e, 1, 6'h30, BMCD_OP_RD_AUX},
		'{16'h0010, 1, 6'h30, BMCD_OP_RD_HK},
		'{16'h0012, 1, 6'h30, BMCD_OP_RD_HK},
		'{16'h0711, 1, 6'h24, BMCD_OP_WIPE_CELL},
		'{16'h0712, 1, 6'h22, BMCD_OP_WIPE_AUX},
		'{16'h0713, 1, 6'h21, BMCD_OP_WIPE_HK},
		'{16'h0714, 1, 6'h20, BMCD_OP_POLL},
		'{16'h0721, 1, 6'h28, BMCD_OP_WR_LINK},
		'{16'h0722, 1, 6'h30, BMCD_OP_RD_LINK},
		'{16'hd002, 1, 6'h30, BMCD_OP_RD_SETUP},
		'{16'hb004, 1, 6'h00, BMCD_OP_NONE},
		'{16'h0804, 1, 6'h00, BMCD_OP_NONE},
		'{16'h0003, 1, 6'h00, BMCD_OP_NONE},
		'{16'h0004, 0, 6'h00, BMCD_OP_NONE},
		'{16'h0722, 1, 6'h30, BMCD_OP_RD_LINK},
		'{16'h0711, 1, 6'h24, BMCD_OP_WIPE_CELL}};
	assign pl = {cmd_accept_o, read_group_o, write_group_o,
		wipe_cells_o, wipe_aux_o, wipe_hk_o};
	bmcd_host_model host (.clock_i, .cmd_valid_o(cmd_valid_i),
		.cmd_word_o(cmd_word_i), .pec_ok_o(pec_ok_i));
	bmcd_top dut (.clock_i, .arst_n_i, .cmd_valid_i, .cmd_word_i,
		.pec_ok_i, .dev_addr_i, .rate_table_alt_i, .cmd_accept_o, .cmd_o,
		.read_group_o, .write_group_o, .conv_start_o, .wipe_cells_o,
		.wipe_aux_o, .wipe_hk_o, .busy_o, .poll_busy_o, .discharge_hold_o,
		.bias_pull_up_o, .cell_enable_o, .aux_enable_o, .hk_enable_o,
		.self_check_o, .self_check_value_o);
	always #10 clock_i = ~clock_i;
	always @(posedge clock_i) cyc <= cyc + 1;
	task automatic chk_vec(input logic [23:0] g, e, input string m);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk_vec
	task automatic chk_op(input bmcd_op_t g, e, input string m);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: %s got %0d exp %0d", $time, m, g, e);
		end
	endtask : chk_op
	task automatic complete_run;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task automatic start(input logic [15:0] w, input bmcd_op_t op);
		host.send(w, 1'b1);
		#1;
		t0 = cyc;
		chk_vec({conv_start_o, busy_o}, 2'b11, "start");
		chk_op(cmd_o.op, op, "start op");
	endtask : start
	task automatic wait_idle(input int n);
		while (busy_o === 1'b1 && cyc - t0 < n + 100) begin
			@(posedge clock_i);
			#1;
		end
		chk_vec(cyc - t0 >= n - 1 && cyc - t0 <= n + 1, 1, "conv time");
		if (busy_o !== 1'b0)
			complete_run();
	endtask : wait_idle
	task automatic do_reset;
		arst_n_i <= 1'b0;
		@(posedge clock_i);
		#1;
		chk_vec({busy_o, conv_start_o, self_check_o}, 3'b000, "reset");
		arst_n_i <= 1'b1;
		repeat (3) @(posedge clock_i);
	endtask : do_reset
	initial begin
		clock_i = 1'b0;
		arst_n_i = 1'b0;
		dev_addr_i = 4'ha;
		rate_table_alt_i = 1'b0;
		last = BMCD_OP_NONE;
		repeat (8) @(posedge clock_i);
		chk_op(cmd_o.op, BMCD_OP_NONE, "reset op");
		arst_n_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		foreach (rows[i]) begin
			host.send(rows[i].w, rows[i].packet_error_code);
			#1;
			if (rows[i].pl[5])
				last = rows[i].op;
			chk_vec(pl, rows[i].pl, "pulses");
			chk_op(cmd_o.op, last, "op");
		end
		start(16'h02e3, BMCD_OP_CONV_CELLS);
		chk_vec({discharge_hold_o, cell_enable_o}, 13'h1104, "pair");
		chk_vec(cmd_o.rate, 3'd0, "rate");
		host.send(16'h04e3, 1'b1);
		#1;
		chk_vec(conv_start_o, 1'b0, "start while busy");
		host.send(16'h0714, 1'b1);
		#1;
		chk_vec(poll_busy_o, 1'b1, "poll busy");
		chk_vec({discharge_hold_o, cell_enable_o}, 13'h1104, "kept");
		wait_idle(`BMCD_US_CYC(`BMCD_T_ONE_27K_US));
		start(16'h02f9, BMCD_OP_CONV_OW);
		chk_vec({discharge_hold_o, bias_pull_up_o}, 2'b01, "bias");
		chk_vec(cell_enable_o, 12'h041, "pair one");
		wait_idle(`BMCD_US_CYC(`BMCD_T_ONE_27K_US));
		start(16'h04ed, BMCD_OP_CONV_AUX);
		chk_vec(aux_enable_o, 6'h10, "gpio five");
		wait_idle(`BMCD_US_CYC(`BMCD_T_ONE_27K_US));
		start(16'h0715, BMCD_OP_MUX_CHECK);
		host.send(16'h0714, 1'b1);
		#1;
		chk_vec(poll_busy_o, 1'b1, "mux poll");
		do_reset();
		start(16'h02a7, BMCD_OP_CELL_ST);
		@(posedge clock_i);
		#1;
		chk_vec(self_check_o, 1'b1, "self flag");
		chk_vec(self_check_value_o, 16'h9565, "self value");
		do_reset();
		rate_table_alt_i <= 1'b1;
		start(16'h0547, BMCD_OP_AUX_ST);
		@(posedge clock_i);
		#1;
		chk_vec(self_check_o, 1'b1, "alt flag");
		chk_vec(self_check_value_o, 16'h6aaa, "alt value");
		chk_vec(cmd_o.rate, 3'd3, "alt rate");
		do_reset();
		start(16'h04ff, BMCD_OP_CONV_CAX);
		chk_vec({cell_enable_o, aux_enable_o}, 18'h3ffc3, "all");
		do_reset();
		start(16'h04ef, BMCD_OP_CONV_CAX);
		chk_vec(discharge_hold_o, 1'b1, "all held");
		do_reset();
		start(16'h04e8, BMCD_OP_CONV_HK);
		chk_vec(hk_enable_o, 4'hf, "hk all");
		do_reset();
		start(16'h04af, BMCD_OP_HK_ST);
		chk_vec(hk_enable_o, 4'hf, "hk self");
		complete_run();
	end
endmodule : tb_battery_monitor_cmd_decoder
`default_nettype wire
